/* File: tb/fcs_host_model.sv */
`default_nettype none
module fcs_host_model (
  input wire logic clk, // Core clock, paces the link
  output logic sclk, // Serial clock, still outside frames
  output logic cs_n, // Chip select, active low
  output logic [3:0] dq, // Host side of the data lanes
  input wire logic [3:0] dq_o // Data lanes as seen at the pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq = 4'h5;
  end
  task automatic half();
    repeat (8) @(negedge clk); // 64 ns period, under every ceiling
  endtask
  // Released lanes toggle so no stale value can pass for data
  task automatic xfer(input logic [7:0] tx, input int n, input bit rd,
                      output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int c = 0; c < 8 / n; c++) begin
      if (rd) dq = ~dq;
      else dq = sh[7:4] >> (4 - n);
      sh = sh << n;
      half();
      sclk = 1'b1;
      rx = (rx << n) | 8'(n == 1 ? {3'h0, dq_o[1]} : dq_o & 4'((1 << n) - 1));
      half();
      sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd,
                       input int nb, input int n, input bit rd,
                       output logic [7:0] rx);
    logic [7:0] d;
    rx = 8'h00;
    cs_n = 1'b0;
    half();
    xfer(cmd, n, 1'b0, d); // Opcode first, no address
    if (nb > 0) xfer(wd, n, rd, rx);
    if (nb > 1) xfer(wd, n, rd, d);
    half();
    cs_n = 1'b1;
    dq = ~dq;
    repeat (3) half();
  endtask
endmodule
`default_nettype wire

/* File: tb/fcs_regs_chk.sv */
`default_nettype none
module fcs_regs_chk (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic cs_n, // Chip select, active low
  input wire logic pe_busy, // Program or erase running
  input wire logic erase_susp, // Erase suspend level
  input wire logic prog_susp, // Program suspend level
  input wire logic erase_fail, // Erase failure pulse
  input wire logic prog_fail, // Program failure pulse
  input wire logic prot_fail, // Protection failure pulse
  input wire logic prog_start, // Program start pulse
  input wire logic cmd_refused, // Refused start pulse
  input wire fcs_pkg::fcs_proto_t proto, // Active protocol
  input wire logic hold_reset_en, // Hold/reset enable
  input wire logic [2:0] drive_strength, // Driver code
  input wire logic [7:0] cfg_value, // Configuration register
  input wire logic [7:0] flag_status // Flag register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] err;
  assign err = {flag_status[5:4], flag_status[1]};
  property p_ready;
    $past(reset_n) |-> flag_status[7] == !$past(pe_busy);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flag wrong");
  property p_esusp;
    $past(reset_n) |-> flag_status[6] == $past(erase_susp);
  endproperty
  a_esusp: assert property (p_esusp)
    else $error("erase suspend flag wrong");
  property p_psusp;
    $past(reset_n) |-> flag_status[2] == $past(prog_susp);
  endproperty
  a_psusp: assert property (p_psusp)
    else $error("program suspend flag wrong");
  property p_eerr; erase_fail |=> flag_status[5]; endproperty
  a_eerr: assert property (p_eerr)
    else $error("erase error flag not set");
  property p_perr; prog_fail |=> flag_status[4]; endproperty
  a_perr: assert property (p_perr)
    else $error("program error flag not set");
  property p_prot; prot_fail |=> flag_status[1]; endproperty
  a_prot: assert property (p_prot)
    else $error("protection flag not set");
  property p_sticky;
    |(~err & $past(err)) |-> cs_n && $past(cs_n, 3);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag dropped outside clear");
  property p_refuse;
    prog_start && |err |=> cmd_refused ##[0:2] flag_status[4];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("start with pending error not refused");
  property p_rsv;
    !flag_status[3] && !flag_status[0] && !cfg_value[5] && !cfg_value[3];
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bit not zero");
  property p_fields;
    hold_reset_en == cfg_value[4] && drive_strength == cfg_value[2:0] &&
    proto == (!cfg_value[7] ? fcs_pkg::FCS_QUAD :
      (!cfg_value[6] ? fcs_pkg::FCS_DUAL : fcs_pkg::FCS_EXT));
  endproperty
  a_fields: assert property (p_fields)
    else $error("configuration outputs disagree");
  property p_wr; $changed(cfg_value) |-> cs_n; endproperty
  a_wr: assert property (p_wr)
    else $error("configuration changed inside frame");
endmodule
bind fcs_regs fcs_regs_chk u_chk (
  .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .pe_busy(pe_busy),
  .erase_susp(erase_susp), .prog_susp(prog_susp),
  .erase_fail(erase_fail), .prog_fail(prog_fail), .prot_fail(prot_fail),
  .prog_start(prog_start), .cmd_refused(cmd_refused), .proto(proto),
  .hold_reset_en(hold_reset_en), .drive_strength(drive_strength),
  .cfg_value(cfg_value), .flag_status(flag_status)
);
`default_nettype wire

/* File: tb/tb_fcs_regs.sv */
`default_nettype none
module tb_fcs_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic pe_busy = 1'b0, erase_susp = 1'b0, prog_susp = 1'b0;
  logic erase_fail = 1'b0, prog_fail = 1'b0, prot_fail = 1'b0;
  logic prog_start = 1'b0, erase_start = 1'b0;
  logic sclk, cs_n, cmd_refused, hold_reset_en;
  logic [3:0] host_dq, dq_i, dq_o, dq_oe;
  logic [2:0] drive_strength;
  logic [7:0] cfg_value, flag_status, rx, w, cfg_e;
  logic [7:0] pt [4] = '{8'hbf, 8'h3f, 8'h7d, 8'hd7};
  logic [31:0] lfsr = 32'hd71448d3;
  fcs_pkg::fcs_proto_t proto;
  int n_fail = 0;
  int checks = 0;
  always #2 clk = ~clk;
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & host_dq);
  fcs_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n),
    .dq(host_dq), .dq_o(dq_i));
  fcs_regs u_dut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .pe_busy(pe_busy),
    .erase_susp(erase_susp), .prog_susp(prog_susp),
    .erase_fail(erase_fail), .prog_fail(prog_fail), .prot_fail(prot_fail),
    .prog_start(prog_start), .erase_start(erase_start),
    .cmd_refused(cmd_refused), .proto(proto), .hold_reset_en(hold_reset_en),
    .drive_strength(drive_strength), .cfg_value(cfg_value),
    .flag_status(flag_status));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reserved driver codes keep the old code
  function automatic logic [7:0] cfg_exp(input logic [7:0] o, wv);
    logic [7:0] e;
    e = wv & 8'hd7;
    if (wv[2:0] == 3'h0 || wv[2:0] == 3'h4) e[2:0] = o[2:0];
    return e;
  endfunction
  function automatic int lanes(input logic [7:0] c);
    return !c[7] ? 4 : (!c[6] ? 2 : 1);
  endfunction
  function automatic logic [7:0] pexp(input logic [7:0] c);
    return !c[7] ? 8'h02 : (!c[6] ? 8'h01 : 8'h00);
  endfunction
  task automatic cmp8(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wcfg(input logic [7:0] wv);
    u_host.frame(8'h61, wv, 1, lanes(cfg_e), 1'b0, rx);
    cfg_e = cfg_exp(cfg_e, wv);
    cmp8("cfg_value", cfg_e, cfg_value);
    cmp8("proto", pexp(cfg_e), 8'(proto));
    cmp8("hold", {7'h0, cfg_e[4]}, {7'h0, hold_reset_en});
    cmp8("drive", {5'h0, cfg_e[2:0]}, {5'h0, drive_strength});
    u_host.frame(8'h65, 8'h00, 1, lanes(cfg_e), 1'b1, rx);
    cmp8("cfg_read", cfg_e, rx);
  endtask
  task automatic rflag(input logic [7:0] e);
    u_host.frame(8'h70, 8'h00, 1, lanes(cfg_e), 1'b1, rx);
    cmp8("flag_read", e, rx);
    cmp8("flag_status", e, flag_status);
  endtask
  task automatic clr(input int nb);
    u_host.frame(8'h50, 8'h00, nb, lanes(cfg_e), 1'b0, rx);
  endtask
  // Refusal stands for one cycle only, so it is looked at right after
  task automatic pulse(ref logic s, input logic e);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
    cmp8("cmd_refused", {7'h0, e}, {7'h0, cmd_refused});
    @(negedge clk);
  endtask
  initial begin
    #300us;
    n_fail++;
    results();
  end
  initial begin
    cfg_e = 8'hd7;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    cmp8("cfg_value", 8'hd7, cfg_value);
    cmp8("dq_oe", 8'h00, {4'h0, dq_oe});
    rflag(8'h80);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      w = i == 0 ? 8'hf8 : (i == 1 ? 8'he4 : lfsr[7:0] | 8'hc0);
      wcfg(w);
    end
    $display("test config done");
    foreach (pt[i]) begin
      wcfg(pt[i]);
      rflag(8'h80);
    end
    u_host.frame(8'h00, 8'h12, 1, lanes(cfg_e), 1'b0, rx);
    cmp8("cfg_value", cfg_e, cfg_value);
    $display("test protocol done");
    @(negedge clk);
    pe_busy = 1'b1;
    erase_susp = 1'b1;
    prog_susp = 1'b1;
    rflag(8'h44);
    pe_busy = 1'b0;
    erase_susp = 1'b0;
    prog_susp = 1'b0;
    repeat (2) @(negedge clk);
    cmp8("flag_status", 8'h80, flag_status);
    pulse(erase_fail, 1'b0);
    rflag(8'ha0);
    clr(0);
    rflag(8'h80);
    pulse(prot_fail, 1'b0);
    rflag(8'h82);
    pulse(prog_start, 1'b1);
    rflag(8'h92);
    pulse(erase_start, 1'b1);
    rflag(8'hb2);
    clr(2);
    rflag(8'hb2);
    clr(0);
    pulse(prog_fail, 1'b0);
    rflag(8'h90);
    clr(0);
    pulse(prog_start, 1'b0);
    rflag(8'h80);
    $display("test flags done");
    results();
  end
endmodule
`default_nettype wire

/* File: verilog/fcs_pin_sync.sv */
`default_nettype none
module fcs_pin_sync (
  input wire logic clk,          // Core clock
  input wire logic reset_n,      // Synchronous reset, active low
  input wire logic sclk,         // Serial clock pin
  input wire logic cs_n,         // Chip select pin, active low
  input wire logic [3:0] dq_i,   // Data pins, input side
  fcs_ser_if.src ser             // Synchronised events to core
);
  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic cs_m;
    logic cs_s;
    logic [3:0] dq_m;
    logic [3:0] dq_s;
  } fcs_sync_t;

  localparam fcs_sync_t SYNC_RST = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
                                     4'h0, 4'h0};

  fcs_sync_t q;
  fcs_sync_t d;

  // -------------------------------------------------------------------
  // Two-stage capture; the second stage feeds logic, with a third sclk stage for edge detection
  // -------------------------------------------------------------------
  always_comb begin
    d = q;
    d.sclk_m = sclk;
    d.sclk_s = q.sclk_m;
    d.sclk_p = q.sclk_s;
    d.cs_m = cs_n;
    d.cs_s = q.cs_m;
    d.dq_m = dq_i;
    d.dq_s = q.dq_m;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= SYNC_RST;
    end else begin
      q <= d;
    end
  end

  assign ser.sclk_rise = q.sclk_s & ~q.sclk_p;
  assign ser.sclk_fall = ~q.sclk_s & q.sclk_p;
  assign ser.sel = ~q.cs_s;
  assign ser.dq = q.dq_s;
endmodule
`default_nettype wire

/* File: verilog/fcs_pkg.sv */
// Functional notes
// RULE_01: Host keeps clock within dummy-cycle frequency ceiling.
// RULE_02: Config bit 7 low selects quad protocol.
// RULE_03: Config bit 6 low selects dual protocol.
// RULE_04: Both low means quad; applies after write.
// RULE_05: Config bit 4 enables hold/reset function.
// RULE_06: Bits 2:0 drive strength; default 111.
// RULE_07: Config readable and writable in every protocol.
// RULE_08: Flag bit 7 low while program/erase busy.
// RULE_09: Ready bit ignores plain write command cycles.
// RULE_10: Flag bit 6 shows erase suspend.
// RULE_11: Flag bit 2 shows program suspend.
// RULE_12: Flag bit 5 sets on erase failure.
// RULE_13: Flag bit 4 sets on program failure.
// RULE_14: Flag bit 1 sets on protection violation.
// RULE_15: Status bits follow their conditions automatically.
// RULE_16: Error bits stay set until clear command.
// RULE_17: Program/erase with error pending is error.
// RULE_18: Flags volatile, readable; bits 3,0 reserved.
// RULE_19: Read flags 70h, config read 65h, write 61h.
// RULE_20: Clear flags 50h, no address or data.
// RULE_21: Reserved bits always read back zero.
`default_nettype none
package fcs_pkg;
  typedef enum logic [1:0] {FCS_EXT, FCS_DUAL, FCS_QUAD} fcs_proto_t;

  // -------------------------------------------------------------------
  // Command codes
  // -------------------------------------------------------------------
  localparam logic [7:0] CMD_RD_FLAG = 8'h70;
  localparam logic [7:0] CMD_RD_CFG = 8'h65;
  localparam logic [7:0] CMD_WR_CFG = 8'h61;
  localparam logic [7:0] CMD_CLR_FLAG = 8'h50;

  // -------------------------------------------------------------------
  // Enhanced volatile configuration layout
  // -------------------------------------------------------------------
  localparam int CFG_QUAD_BIT = 7;
  localparam int CFG_DUAL_BIT = 6;
  localparam int CFG_HOLD_BIT = 4;
  localparam int CFG_DRV_LSB = 0;
  localparam int CFG_DRV_W = 3;
  localparam logic [7:0] CFG_WR_MASK = 8'hd7;
  localparam logic [7:0] CFG_RST = 8'hd7;
  localparam logic [2:0] DRV_RSV_A = 3'h0;
  localparam logic [2:0] DRV_RSV_B = 3'h4;

  // -------------------------------------------------------------------
  // Flag status layout
  // -------------------------------------------------------------------
  localparam int FLG_READY_BIT = 7;
  localparam int FLG_ESUSP_BIT = 6;
  localparam int FLG_EERR_BIT = 5;
  localparam int FLG_PERR_BIT = 4;
  localparam int FLG_PSUSP_BIT = 2;
  localparam int FLG_PROT_BIT = 1;
  localparam logic [7:0] FLG_RST = 8'h80;

  // -------------------------------------------------------------------
  // Serial lane bookkeeping
  // -------------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  function automatic fcs_proto_t fcs_proto_of(input logic [7:0] cfg);
    if (!cfg[CFG_QUAD_BIT]) begin
      fcs_proto_of = FCS_QUAD;
    end else if (!cfg[CFG_DUAL_BIT]) begin
      fcs_proto_of = FCS_DUAL;
    end else begin
      fcs_proto_of = FCS_EXT;
    end
  endfunction

  function automatic logic [3:0] fcs_lanes(input fcs_proto_t p);
    unique case (p)
      FCS_EXT: fcs_lanes = 4'h1;
      FCS_DUAL: fcs_lanes = 4'h2;
      FCS_QUAD: fcs_lanes = 4'h4;
      default: fcs_lanes = 4'h1;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: verilog/fcs_regs.sv */
`default_nettype none
module fcs_regs (
  input wire logic clk,            // Core clock, 250 MHz
  input wire logic reset_n,        // Synchronous reset, active low
  input wire logic sclk,           // Serial clock pin
  input wire logic cs_n,           // Chip select pin, active low
  input wire logic [3:0] dq_i,     // Data pins, input side
  output logic [3:0] dq_o,         // Data pins, output side
  output logic [3:0] dq_oe,        // Data pins, high while driven
  input wire logic pe_busy,        // Program or erase cycle running
  input wire logic erase_susp,     // Erase suspended or suspending
  input wire logic prog_susp,      // Program suspended or suspending
  input wire logic erase_fail,     // Erase failed, one-cycle pulse
  input wire logic prog_fail,      // Program failed, one-cycle pulse
  input wire logic prot_fail,      // Protection violation, pulse
  input wire logic prog_start,     // Program command accepted, pulse
  input wire logic erase_start,    // Erase command accepted, pulse
  output logic cmd_refused,        // Start met pending error, pulse
  output fcs_pkg::fcs_proto_t proto, // Active protocol
  output logic hold_reset_en,      // Hold/reset input function on
  output logic [2:0] drive_strength, // Output driver code
  output logic [7:0] cfg_value,    // Configuration register contents
  output logic [7:0] flag_status   // Flag status register contents
);
  typedef enum logic [2:0] {
    ST_CMD, ST_RD_FLAG, ST_RD_CFG, ST_WR_CFG, ST_WR_HAVE, ST_CLR, ST_SKIP
  } fcs_state_t;

  typedef struct packed {
    fcs_state_t st;
    logic [7:0] cfg;
    logic [7:0] wr_byte;
    logic eerr;
    logic perr;
    logic prot;
    logic [7:0] flg;
    logic refused;
    logic sel_p;
  } fcs_regs_t;

  localparam fcs_regs_t REGS_RST = '{ST_CMD, fcs_pkg::CFG_RST, 8'h00,
                                     1'b0, 1'b0, 1'b0, fcs_pkg::FLG_RST,
                                     1'b0, 1'b0};

  fcs_ser_if ser ();

  fcs_regs_t q;
  fcs_regs_t d;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic out_en;
  logic cs_rise;
  logic any_err;
  logic e_set;
  logic p_set;
  logic x_set;
  logic clr;
  logic [7:0] wr_cfg;

  // -------------------------------------------------------------------
  // Pin capture and serial shifting
  // -------------------------------------------------------------------
  fcs_pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .dq_i(dq_i),
    .ser(ser)
  );

  fcs_shifter u_shift (
    .clk(clk),
    .reset_n(reset_n),
    .ser(ser),
    .proto(proto),
    .tx_byte(tx_byte),
    .out_en(out_en),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .dq_o(dq_o),
    .dq_oe(dq_oe)
  );

  // -------------------------------------------------------------------
  // Register read-out
  // -------------------------------------------------------------------
  assign out_en = (q.st == ST_RD_FLAG) || (q.st == ST_RD_CFG); // [RULE_07]
  assign tx_byte = (q.st == ST_RD_CFG) ? q.cfg : q.flg; // [RULE_18]
  assign cs_rise = q.sel_p & ~ser.sel;

  // -------------------------------------------------------------------
  // Error flag events
  // -------------------------------------------------------------------
  assign any_err = q.eerr | q.perr | q.prot;
  assign e_set = erase_fail | (erase_start & any_err); // [RULE_12] [RULE_17]
  assign p_set = prog_fail | (prog_start & any_err); // [RULE_13] [RULE_17]
  assign x_set = prot_fail; // [RULE_14]
  assign clr = cs_rise && (q.st == ST_CLR); // [RULE_20]

  // Reserved bits forced low; reserved drive codes keep the old code
  always_comb begin
    wr_cfg = q.wr_byte & fcs_pkg::CFG_WR_MASK; // [RULE_21]
    if ((q.wr_byte[2:0] == fcs_pkg::DRV_RSV_A) ||
        (q.wr_byte[2:0] == fcs_pkg::DRV_RSV_B)) begin
      wr_cfg[2:0] = q.cfg[2:0]; // [RULE_06]
    end
  end

  // -------------------------------------------------------------------
  // Command sequencing and register update
  // -------------------------------------------------------------------
  always_comb begin
    d = q;
    d.sel_p = ser.sel;
    d.refused = (prog_start | erase_start) & any_err; // [RULE_17]
    // Set wins over the clear command
    d.eerr = e_set | (q.eerr & ~clr); // [RULE_16]
    d.perr = p_set | (q.perr & ~clr); // [RULE_16]
    d.prot = x_set | (q.prot & ~clr); // [RULE_16]
    if (ser.sel && rx_valid) begin
      unique case (q.st)
        ST_CMD: begin
          unique case (rx_byte)
            fcs_pkg::CMD_RD_FLAG: d.st = ST_RD_FLAG; // [RULE_19]
            fcs_pkg::CMD_RD_CFG: d.st = ST_RD_CFG; // [RULE_19]
            fcs_pkg::CMD_WR_CFG: d.st = ST_WR_CFG; // [RULE_19]
            fcs_pkg::CMD_CLR_FLAG: d.st = ST_CLR; // [RULE_20]
            default: d.st = ST_SKIP;
          endcase
        end
        ST_WR_CFG: begin
          d.wr_byte = rx_byte;
          d.st = ST_WR_HAVE;
        end
        ST_CLR: d.st = ST_SKIP; // [RULE_20]
        ST_RD_FLAG, ST_RD_CFG, ST_WR_HAVE, ST_SKIP: d.st = q.st;
      endcase
    end
    if (cs_rise && (q.st == ST_WR_HAVE)) begin
      d.cfg = wr_cfg; // [RULE_04] [RULE_07]
    end
    if (!ser.sel) begin
      d.st = ST_CMD;
    end
    d.flg = 8'h00; // [RULE_18] [RULE_21]
    d.flg[fcs_pkg::FLG_READY_BIT] = ~pe_busy; // [RULE_08] [RULE_09]
    d.flg[fcs_pkg::FLG_ESUSP_BIT] = erase_susp; // [RULE_10] [RULE_15]
    d.flg[fcs_pkg::FLG_PSUSP_BIT] = prog_susp; // [RULE_11] [RULE_15]
    d.flg[fcs_pkg::FLG_EERR_BIT] = d.eerr; // [RULE_12]
    d.flg[fcs_pkg::FLG_PERR_BIT] = d.perr; // [RULE_13]
    d.flg[fcs_pkg::FLG_PROT_BIT] = d.prot; // [RULE_14]
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // -------------------------------------------------------------------
  // Configuration outputs
  // -------------------------------------------------------------------
  assign proto = fcs_pkg::fcs_proto_of(q.cfg); // [RULE_02] [RULE_03] [RULE_04]
  assign hold_reset_en = q.cfg[fcs_pkg::CFG_HOLD_BIT]; // [RULE_05]
  assign drive_strength =
    q.cfg[fcs_pkg::CFG_DRV_LSB +: fcs_pkg::CFG_DRV_W]; // [RULE_06]
  assign cfg_value = q.cfg;
  assign flag_status = q.flg;
  assign cmd_refused = q.refused;
endmodule
`default_nettype wire

/* File: verilog/fcs_ser_if.sv */
`default_nettype none
interface fcs_ser_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel;
  logic [3:0] dq;
  modport src (output sclk_rise, output sclk_fall, output sel, output dq);
  modport dst (input sclk_rise, input sclk_fall, input sel, input dq);
endinterface
`default_nettype wire

/* File: verilog/fcs_shifter.sv */
`default_nettype none
module fcs_shifter (
  input wire logic clk,                  // Core clock
  input wire logic reset_n,              // Synchronous reset, active low
  fcs_ser_if.dst ser,                    // Synchronised pin events
  input wire fcs_pkg::fcs_proto_t proto, // Active protocol
  input wire logic [7:0] tx_byte,        // Byte to send next
  input wire logic out_en,               // Drive the data lanes
  output logic rx_valid,                 // Byte received, one-cycle pulse
  output logic [7:0] rx_byte,            // Received byte
  output logic [3:0] dq_o,               // Data pins, output side
  output logic [3:0] dq_oe               // Data pins, high while driven
);
  typedef struct packed {
    logic [7:0] rx_sr;
    logic [3:0] rx_cnt;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] tx_sr;
    logic [3:0] tx_cnt;
    logic [3:0] dq_o;
  } fcs_shift_t;

  fcs_shift_t q;
  fcs_shift_t d;
  logic [3:0] lanes;
  logic [7:0] rx_next;
  logic [7:0] tx_cur;

  assign lanes = fcs_pkg::fcs_lanes(proto);

  // -------------------------------------------------------------------
  // Sample on rising edge, shift out on falling edge
  // -------------------------------------------------------------------
  always_comb begin
    d = q;
    d.rx_valid = 1'b0;
    rx_next = q.rx_sr;
    tx_cur = (q.tx_cnt == 4'h0) ? tx_byte : q.tx_sr;
    unique case (proto)
      fcs_pkg::FCS_EXT: rx_next = {q.rx_sr[6:0], ser.dq[0]};
      fcs_pkg::FCS_DUAL: rx_next = {q.rx_sr[5:0], ser.dq[1:0]};
      fcs_pkg::FCS_QUAD: rx_next = {q.rx_sr[3:0], ser.dq};
      default: rx_next = {q.rx_sr[6:0], ser.dq[0]};
    endcase
    if (!ser.sel) begin
      d.rx_cnt = 4'h0;
      d.tx_cnt = 4'h0;
    end else begin
      if (ser.sclk_rise) begin
        d.rx_sr = rx_next;
        if (q.rx_cnt + lanes == fcs_pkg::BITS_PER_BYTE) begin
          d.rx_cnt = 4'h0;
          d.rx_valid = 1'b1;
          d.rx_byte = rx_next;
        end else begin
          d.rx_cnt = q.rx_cnt + lanes;
        end
      end
      if (ser.sclk_fall && out_en) begin
        unique case (proto)
          fcs_pkg::FCS_EXT: d.dq_o = {2'h0, tx_cur[7], 1'b0};
          fcs_pkg::FCS_DUAL: d.dq_o = {2'h0, tx_cur[7:6]};
          fcs_pkg::FCS_QUAD: d.dq_o = tx_cur[7:4];
          default: d.dq_o = {2'h0, tx_cur[7], 1'b0};
        endcase
        d.tx_sr = tx_cur << lanes;
        if (q.tx_cnt == 4'h0) begin
          d.tx_cnt = fcs_pkg::BITS_PER_BYTE - lanes;
        end else begin
          d.tx_cnt = q.tx_cnt - lanes;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    dq_oe = 4'h0;
    if (out_en && ser.sel) begin
      unique case (proto)
        fcs_pkg::FCS_EXT: dq_oe = 4'h2;
        fcs_pkg::FCS_DUAL: dq_oe = 4'h3;
        fcs_pkg::FCS_QUAD: dq_oe = 4'hf;
        default: dq_oe = 4'h2;
      endcase
    end
  end

  assign rx_valid = q.rx_valid;
  assign rx_byte = q.rx_byte;
  assign dq_o = q.dq_o;
endmodule
`default_nettype wire
